// *** core/wscr_defs.svh ***
// width and reset constants for the wide residue mover
`ifndef WSCR_DEFS_SVH
`define WSCR_DEFS_SVH
`define WSCR_CNT_W     24
`define WSCR_BYTE_W    8
`define WSCR_WORD_W    16
`define WSCR_FLAG_RST  1'b0
`endif

// *** core/wscr_pkg.sv ***
// types shared by the wide residue mover
package wscr_pkg;
   // move instruction issued to the block
   typedef struct packed {
      logic        chained_move_op;  // chained versus ordinary move
      logic        initiator;        // role: initiator when set
      logic        data_out;         // phase: data-out when set
      logic [23:0] byte_count;       // memory-side byte count
   } wscr_cmd_t;
   // one byte on the memory side
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } wscr_mbyte_t;
   // one word on the scsi side, lane enables per byte
   typedef struct packed {
      logic        valid;
      logic [1:0]  lanes;
      logic [15:0] data;
   } wscr_sword_t;
endpackage : wscr_pkg

// *** core/wscr_dir.sv ***
// direction decode from phase and role
`timescale 1ns/1ps
module wscr_dir (
   // command fields
   input  wire logic initiator,
   input  wire logic data_out,
   // decoded direction
   output logic      is_receive
);
   // receive: data-in as initiator or data-out as target
   assign is_receive = initiator ^ data_out;
endmodule : wscr_dir

// *** core/wscr_mover.sv ***
// wide scsi residue mover: odd bytes across normal and chained moves
// How it works
// - data-in initiator or data-out target receives
// - chained receive ending partial sets receive flag
// - partial chained receive keeps high byte, not written
// - chained receive with flag and nonzero count writes held byte first
// - residue byte consumes one count byte
// - chained receive, flag clear: plain move
// - ordinary receive ignores residue register
// - chained send odd end holds low byte
// - ordinary send odd end sends last byte
// - send count counts fetched memory bytes
// - send flag set pairs first byte high
// - send flag set only by chained send
// - send flag clears when paired word is formed
// - receive flag clears at next receive start
`timescale 1ns/1ps
`include "wscr_defs.svh"
module wscr_mover (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rstn,
   // command start, one cycle pulse
   input  wire logic                start,
   input  wscr_pkg::wscr_cmd_t      cmd,
   // flag clears from software or program
   input  wire logic                clr_recv_flag,
   input  wire logic                clr_send_flag,
   // scsi side inbound word (receive)
   input  wscr_pkg::wscr_sword_t    scsi_in,
   output logic                     scsi_in_ready,
   // scsi side outbound word (send)
   output wscr_pkg::wscr_sword_t    scsi_out,
   input  wire logic                scsi_out_ready,
   // memory side inbound byte (send)
   input  wscr_pkg::wscr_mbyte_t    mem_in,
   output logic                     mem_in_ready,
   // memory side outbound byte (receive)
   output wscr_pkg::wscr_mbyte_t    mem_out,
   input  wire logic                mem_out_ready,
   // status
   output logic                     busy,
   output logic                     done,
   output logic                     wide_receive_residue_flag,
   output logic                     wide_send_residue_flag,
   output logic [7:0]               receive_residue_byte_reg,
   output logic [15:0]              output_data_latch
);
   import wscr_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_HI, S_TX, S_DONE} wscr_state_t;

   // synchronised reset
   logic rst_s1_ff, rst_s2_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   wire rst_n = rst_s2_ff;

   // scsi word input comes from another domain: two stages before use
   wscr_sword_t si_s1_ff, si_s2_ff;
   logic        si_v3_ff;  // valid seen a cycle earlier, so the data bits have settled
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         si_s1_ff <= '0;
         si_s2_ff <= '0;
         si_v3_ff <= 1'b0;
      end else begin
         si_s1_ff <= scsi_in;
         si_s2_ff <= si_s1_ff;
         si_v3_ff <= si_s2_ff.valid;
      end
   end

   // state and working registers
   wscr_state_t            state_ff, nxt_state;
   logic [`WSCR_CNT_W-1:0] cnt_ff;        // memory bytes left
   logic                   chain_ff;      // current move is chained
   logic                   rx_ff;         // current move receives
   logic [7:0]             hi_ff;         // pending high byte on receive
   logic                   seen_ff;       // word already consumed (edge guard)
   logic                   lo_have_ff;    // low byte gathered on send
   logic [7:0]             lo_ff;         // low byte waiting for its partner
   logic                   hi_lane_ff;    // taken word carries a high byte

   logic is_rx;
   wscr_dir u_dir (
      .initiator  (cmd.initiator),
      .data_out   (cmd.data_out),
      .is_receive (is_rx)
   );

   // handshake terms
   wire cnt_one   = (cnt_ff == `WSCR_CNT_W'(1));
   wire cnt_zero  = (cnt_ff == '0);
   wire mo_fire   = mem_out.valid && mem_out_ready;
   wire mi_fire   = mem_in.valid && mem_in_ready;
   wire so_fire   = scsi_out.valid && scsi_out_ready;
   // a word is taken only with the memory slot free and bytes still owed
   wire rx_take   = (state_ff == S_RX) && si_s2_ff.valid && si_v3_ff && !seen_ff
                    && !mem_out.valid && !cnt_zero;
   // chained receive with flag set delivers residue first
   // a zero-count move has no room for the residue; its start clears the flag, so the residue is dropped
   wire rx_lead   = start && is_rx && cmd.chained_move_op && wide_receive_residue_flag
                    && (cmd.byte_count != '0);
   // high byte of the taken word, once its low byte is written
   wire hi_due    = (state_ff == S_RX_HI) && mo_fire && hi_lane_ff;
   wire hi_send   = hi_due && !cnt_one;
   wire hi_keep   = hi_due && cnt_one && chain_ff;
   // send flag pairs first fetched byte as high byte
   wire tx_pair   = (state_ff == S_TX) && wide_send_residue_flag && !lo_have_ff;

   // state sequencing
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_IDLE:  if (start) nxt_state = (cmd.byte_count == '0) ? S_DONE : (is_rx ? S_RX : S_TX);
         S_RX: begin
            // a taken word waits in the high-byte phase for its low byte
            if (rx_take)                         nxt_state = S_RX_HI;
            else if (cnt_zero && !mem_out.valid) nxt_state = S_DONE;
         end
         S_RX_HI: if (mo_fire) nxt_state = cnt_one ? S_DONE : S_RX;
         S_TX:    if (cnt_zero && !scsi_out.valid) nxt_state = S_DONE;
         S_DONE:  nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) state_ff <= S_IDLE;
      else        state_ff <= nxt_state;
   end

   // command capture and memory-side byte count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff   <= '0;
         chain_ff <= 1'b0;
         rx_ff    <= 1'b0;
      end else if (start && state_ff == S_IDLE) begin
         // residue byte counted against the move
         // send count is memory bytes fetched
         cnt_ff   <= cmd.byte_count;
         chain_ff <= cmd.chained_move_op;
         rx_ff    <= is_rx;
      end else if (mo_fire || mi_fire) begin
         cnt_ff   <= cnt_ff - `WSCR_CNT_W'(1);
      end
   end

   // receive: memory byte output, high byte queued behind low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_out    <= '0;
         hi_ff      <= '0;
         hi_lane_ff <= 1'b0;
         seen_ff    <= 1'b0;
      end else begin
         // guard drops once the peer has let the word go
         if (!si_s2_ff.valid) seen_ff <= 1'b0;
         if (mo_fire) mem_out.valid <= 1'b0;
         if (state_ff == S_IDLE && rx_lead) begin
            // residue first; ordinary moves skip this
            mem_out.valid <= 1'b1;
            mem_out.data  <= receive_residue_byte_reg;
         end else if (rx_take) begin
            seen_ff       <= 1'b1;
            mem_out.valid <= 1'b1;
            mem_out.data  <= si_s2_ff.data[7:0];
            hi_ff         <= si_s2_ff.data[15:8];
            hi_lane_ff    <= si_s2_ff.lanes[1];
         end else if (hi_send) begin
            // high byte follows while the count still owes bytes
            mem_out.valid <= 1'b1;
            mem_out.data  <= hi_ff;
         end
      end
   end

   // receive residue flag and byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wide_receive_residue_flag <= `WSCR_FLAG_RST;
         receive_residue_byte_reg  <= '0;
      end else if (hi_keep) begin
         // partial end of chained receive sets flag
         // high byte held, not written to memory until the next chained receive
         wide_receive_residue_flag <= 1'b1;
         receive_residue_byte_reg  <= hi_ff;
      end else if ((start && state_ff == S_IDLE && is_rx) || clr_recv_flag) begin
         // next receive start or software clears
         // flag clear leaves the move plain
         wide_receive_residue_flag <= 1'b0;
      end
   end

   // send: gather bytes into words toward the bus
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scsi_out   <= '0;
         lo_have_ff <= 1'b0;
         lo_ff      <= '0;
      end else begin
         if (so_fire) scsi_out.valid <= 1'b0;
         if (mi_fire && tx_pair) begin
            // held low byte married with first byte
            scsi_out <= '{valid: 1'b1, lanes: 2'b11, data: {mem_in.data, output_data_latch[7:0]}};
         end else if (mi_fire && !lo_have_ff && cnt_one && !chain_ff) begin
            // ordinary send drives lone last byte
            scsi_out   <= '{valid: 1'b1, lanes: 2'b01, data: {8'h00, mem_in.data}};
         end else if (mi_fire && !lo_have_ff && !(cnt_one && chain_ff)) begin
            lo_have_ff <= 1'b1;
            lo_ff      <= mem_in.data;
         end else if (mi_fire && lo_have_ff) begin
            lo_have_ff <= 1'b0;
            scsi_out   <= '{valid: 1'b1, lanes: 2'b11, data: {mem_in.data, lo_ff}};
         end
      end
   end

   // memory input accepted only while the outbound word slot is free
   // combinational so a byte can be taken the cycle the slot frees
   assign mem_in_ready = (state_ff == S_TX) && !cnt_zero && !scsi_out.valid;

   // send residue flag and output data latch
   wire tx_hold = (state_ff == S_TX) && mi_fire && !lo_have_ff && !tx_pair && cnt_one && chain_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wide_send_residue_flag <= `WSCR_FLAG_RST;
         output_data_latch      <= '0;
      end else if (tx_hold) begin
         // chained send keeps last low byte
         // only a chained send sets flag
         wide_send_residue_flag <= 1'b1;
         output_data_latch      <= {8'h00, mem_in.data};
      end else if ((mi_fire && tx_pair) || clr_send_flag) begin
         // cleared once married word is formed
         wide_send_residue_flag <= 1'b0;
      end
   end

   // receive input ready and status
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scsi_in_ready <= 1'b0;
         busy          <= 1'b0;
         done          <= 1'b0;
      end else begin
         scsi_in_ready <= rx_take;
         busy          <= (nxt_state != S_IDLE);
         done          <= (nxt_state == S_DONE);
      end
   end
   // flags are plain outputs readable at any time
endmodule : wscr_mover

// *** bench/wscr_mover_chk.sv ***
// port assertions for the wide residue mover
`timescale 1ns/1ps
module wscr_mover_chk (
   // clock, reset, command
   input wire logic          clk, rstn, start, busy, clr_recv_flag, clr_send_flag,
   input wscr_pkg::wscr_cmd_t cmd,
   // data sides and flags
   input wscr_pkg::wscr_sword_t scsi_out,
   input wscr_pkg::wscr_mbyte_t mem_out,
   input wire logic          mem_out_ready, wide_receive_residue_flag, wide_send_residue_flag
);
   logic ch_ff, rx_ff;  // kind of the move last taken
   // capture only taken starts, a start while busy is refused
   always_ff @(posedge clk or negedge rstn)
      if (!rstn) {ch_ff, rx_ff} <= 2'b00;
      else if (start && !busy) {ch_ff, rx_ff} <= {cmd.chained_move_op, cmd.initiator ^ cmd.data_out};
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_rx_mem; mem_out.valid |-> rx_ff; endproperty
   a_rx_mem: assert property (p_rx_mem) else $error("memory write in a send move");
   property p_tx_bus; scsi_out.valid |-> !rx_ff; endproperty
   a_tx_bus: assert property (p_tx_bus) else $error("bus word in a receive move");
   property p_wsr_set; $rose(wide_receive_residue_flag) |-> ch_ff && rx_ff; endproperty
   a_wsr_set: assert property (p_wsr_set) else $error("receive flag set by wrong move");
   property p_wss_set; $rose(wide_send_residue_flag) |-> ch_ff && !rx_ff; endproperty
   a_wss_set: assert property (p_wss_set) else $error("send flag set by wrong move");
   property p_odd_send; scsi_out.valid && scsi_out.lanes == 2'b01 |-> !ch_ff; endproperty
   a_odd_send: assert property (p_odd_send) else $error("chained send drove odd byte");
   property p_wss_clr; clr_send_flag && !busy && !start |=> !wide_send_residue_flag; endproperty
   a_wss_clr: assert property (p_wss_clr) else $error("send flag not cleared");
   property p_wsr_clr; clr_recv_flag && !busy && !start |=> !wide_receive_residue_flag; endproperty
   a_wsr_clr: assert property (p_wsr_clr) else $error("receive flag not cleared");
   property p_wsr_start;
      start && !busy && (cmd.initiator ^ cmd.data_out) |-> ##[1:3] !wide_receive_residue_flag;
   endproperty
   a_wsr_start: assert property (p_wsr_start) else $error("receive flag kept at start");
   property p_mem_hold; mem_out.valid && !mem_out_ready |=> mem_out.valid && $stable(mem_out.data); endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("memory byte dropped early");
   c_wss: cover property ($rose(wide_send_residue_flag));
   c_wsr: cover property ($rose(wide_receive_residue_flag));
   c_odd: cover property (scsi_out.valid && scsi_out.lanes == 2'b01);
endmodule : wscr_mover_chk
bind wscr_mover wscr_mover_chk u_chk (.*);

// *** bench/wscr_peer.sv ***
// far side: host memory and wide bus peer, both stalling at random
`timescale 1ns/1ps
module wscr_peer (
   input wire logic              clk,
   // memory side
   output wscr_pkg::wscr_mbyte_t mem_in,
   input wire logic              mem_in_ready,
   input wscr_pkg::wscr_mbyte_t  mem_out,
   output logic                  mem_out_ready,
   // bus side
   output wscr_pkg::wscr_sword_t scsi_in,
   input wire logic              scsi_in_ready,
   input wscr_pkg::wscr_sword_t  scsi_out,
   output logic                  scsi_out_ready
);
   logic [7:0]  src[$], got[$];  // bytes to fetch, bytes written
   logic [15:0] win[$];          // words still to hand in
   logic [17:0] wout[$];         // lanes and data seen, odd word masked
   logic        mt, st, mv;
   initial {mem_in, scsi_in, mem_out_ready, scsi_out_ready} = '0;
   // sample at the edge, answer just after it
   always @(posedge clk) begin
      if (mem_out.valid && mem_out_ready) got.push_back(mem_out.data);
      if (scsi_out.valid && scsi_out_ready)
         wout.push_back({scsi_out.lanes, scsi_out.lanes == 2'b01 ? {8'h00, scsi_out.data[7:0]} : scsi_out.data});
      mt = mem_in.valid && mem_in_ready;
      st = scsi_in.valid && scsi_in_ready;
      #1;
      mem_out_ready = $urandom_range(0, 2) != 0;
      scsi_out_ready = $urandom_range(0, 2) != 0;
      if (mt) void'(src.pop_front());
      // an idle byte lane shows the inverse so a stale byte never matches
      if (mt || !mem_in.valid) begin
         mv = src.size() > 0 && $urandom_range(0, 2) != 0;
         mem_in = {mv, mv ? src[0] : ~mem_in.data};
      end
      // hold a word until taken, then idle for at least a cycle
      if (st) begin
         void'(win.pop_front());
         scsi_in = {3'b000, ~scsi_in.data};
      end else if (!scsi_in.valid && win.size() > 0 && $urandom_range(0, 1))
         scsi_in = {3'b111, win[0]};
   end
endmodule : wscr_peer

// *** bench/wscr_mover_tb.sv ***
// self-checking bench for the wide residue mover
`timescale 1ns/1ps
module wscr_mover_tb;
   import wscr_pkg::*;
   logic        clk = 0, rstn = 0, start = 0, clr_recv_flag = 0, clr_send_flag = 0;
   wscr_cmd_t   cmd = '0;
   wscr_sword_t scsi_in, scsi_out;
   wscr_mbyte_t mem_in, mem_out;
   logic        scsi_in_ready, scsi_out_ready, mem_in_ready, mem_out_ready, busy, done;
   logic        wide_receive_residue_flag, wide_send_residue_flag, ewss = 0, ewsr = 0;
   logic [7:0]  receive_residue_byte_reg, eheld, eres, eb[$];
   logic [15:0] output_data_latch;
   logic [17:0] ew[$];  // expected bus words with lanes
   int          n_mismatch = 0, num_checks = 0, k;
   logic [7:0]  t[11] = '{8'h05, 8'h85, 8'h03, 8'h81, 8'h81, 8'hc3, 8'hc3, 8'hc1, 8'h42, 8'hc1, 8'h83};
   always #10 clk = ~clk;
   wscr_mover u_dut (.*);
   wscr_peer u_peer (.*);
   // send: pair held byte first, odd tail held only by a chained move
   function automatic void exp_send(bit ch, int n);
      logic [7:0] b[$];
      int i;
      for (i = 0; i < n; i++) b.push_back(8'($urandom));
      u_peer.src = b;
      i = 0;
      if (ewss) begin ew.push_back({2'b11, b[0], eheld}); ewss = 0; i = 1; end
      for (; i + 1 < n; i += 2) ew.push_back({2'b11, b[i + 1], b[i]});
      if (i < n && ch) begin ewss = 1; eheld = b[i]; end
      else if (i < n) ew.push_back({2'b01, 8'h00, b[i]});
   endfunction : exp_send
   // receive: residue byte counts as one, ordinary moves ignore it
   function automatic void exp_recv(bit ch, int n);
      logic [15:0] w;
      int i;
      i = 0;
      if (ch && ewsr) begin eb.push_back(eres); i = 1; end
      ewsr = 0;
      while (i < n) begin
         w = 16'($urandom);
         u_peer.win.push_back(w);
         eb.push_back(w[7:0]);
         i++;
         if (i < n) begin eb.push_back(w[15:8]); i++; end
         else if (ch) begin ewsr = 1; eres = w[15:8]; end
      end
   endfunction : exp_recv
   task automatic chk(string s, logic [23:0] e, logic [23:0] g);
      num_checks++;
      if (g !== e) begin n_mismatch++; $display("MISMATCH %s expected %h seen %h", s, e, g); end
   endtask : chk
   task automatic run(bit ch, bit rx, int n);
      bit ini;
      ini = 1'($urandom_range(0, 1));
      ew.delete(); eb.delete(); u_peer.got.delete(); u_peer.wout.delete();
      if (rx) exp_recv(ch, n); else exp_send(ch, n);
      @(posedge clk); #1;
      start = 1;
      cmd = {ch, ini, ini ^ rx, 24'(n)};
      // start stays up over a busy edge, where it must be refused
      @(posedge clk); @(posedge clk); #1;
      start = 0;
      k = 0;
      do begin @(posedge clk); #1; k++; end while (done !== 1'b1 && k < 500);
      repeat (2) @(posedge clk);
      #1;
      chk("timeout", 0, 24'(k >= 500));
      chk("word count", 24'(ew.size()), 24'(u_peer.wout.size()));
      foreach (ew[i]) chk("bus word", ew[i], u_peer.wout[i]);
      chk("byte count", 24'(eb.size()), 24'(u_peer.got.size()));
      foreach (eb[i]) chk("memory byte", eb[i], u_peer.got[i]);
      chk("send flag", ewss, wide_send_residue_flag);
      chk("receive flag", ewsr, wide_receive_residue_flag);
      if (ewss) chk("latch", eheld, output_data_latch[7:0]);
      if (ewsr) chk("residue", eres, receive_residue_byte_reg);
      $display("test end ch=%0d rx=%0d n=%0d", ch, rx, n);
   endtask : run
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   initial begin
      void'($urandom(32'h1a8a));
      repeat (4) @(posedge clk);
      #1 rstn = 1;
      repeat (3) @(posedge clk);
      foreach (t[i]) run(t[i][7], t[i][6], int'(t[i][5:0]));
      @(posedge clk); #1;
      {clr_recv_flag, clr_send_flag} = 2'b11;
      @(posedge clk); #1;
      {clr_recv_flag, clr_send_flag, ewss, ewsr} = 4'h0;
      chk("send clear", 0, wide_send_residue_flag);
      chk("receive clear", 0, wide_receive_residue_flag);
      repeat (24) run(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)), $urandom_range(1, 7));
      summarize();
   end
   // watchdog well beyond the expected run length
   initial begin #400000; n_mismatch++; summarize(); end
endmodule : wscr_mover_tb
